// ### rtl/csbpi_pkg.sv
// Shared constants and types for the system bus pin interface
package csbpi_pkg;
  localparam int ADDR_W = 24;
  localparam int UPPER_W = 8;
  localparam int LANE_W = 4;
  localparam int CODE_W = 4;
  localparam int DATA_W = ADDR_W + UPPER_W;
  localparam logic [CODE_W-1:0] CODE_IDLE = 4'h0;
  localparam logic [LANE_W-1:0] LANES_NONE = 4'hf;
  // Reset/abort low time, in clocks, that separates abort from reset
  localparam int ABORT_CLKS = 1;
  localparam logic [3:0] ABORT_CNT = 4'(ABORT_CLKS);
  typedef enum logic [2:0] {CSB_IDLE, CSB_ADDR, CSB_DATA, CSB_WAIT, CSB_HELD} csbpi_state_t;
endpackage

// ### rtl/csbpi_if.sv
// Pin-level carrier between the processor end and the system end
`timescale 1ns/100ps
`default_nettype none
interface csbpi_if;
  import csbpi_pkg::*;
  logic addr_strobe_n;
  logic addr_strobe_oe;
  logic transfer_dir;
  logic transfer_dir_oe;
  logic flow_pulse_n;
  logic [CODE_W-1:0] cycle_code;
  logic interlock_flag_n;
  logic user_mode;
  logic [LANE_W-1:0] byte_lane_en_n;
  logic byte_lane_oe;
  logic [DATA_W-1:0] ad_cpu;
  logic ad_cpu_oe;
  logic [DATA_W-1:0] ad_sys;
  logic ad_sys_oe;
  logic bus_grant_ack_n;
  logic hold_req_n;
  logic ready;
  logic int_req_n;
  logic nmi_req_n;
  logic reset_abort_n;
  logic strobe_or_float_cpu;
  logic strobe_or_float_cpu_oe;
  logic float_cmd_n;
  logic xlate_cpu;
  logic xlate_cpu_oe;
  logic xlate_sys;
  logic xlate_sys_oe;
  modport cpu (
    output addr_strobe_n, addr_strobe_oe, transfer_dir, transfer_dir_oe, flow_pulse_n,
    output cycle_code, interlock_flag_n, user_mode, byte_lane_en_n, byte_lane_oe,
    output ad_cpu, ad_cpu_oe, bus_grant_ack_n, strobe_or_float_cpu, strobe_or_float_cpu_oe,
    output xlate_cpu, xlate_cpu_oe,
    input ad_sys, ad_sys_oe, hold_req_n, ready, int_req_n, nmi_req_n, reset_abort_n,
    input float_cmd_n, xlate_sys, xlate_sys_oe
  );
  modport sys (
    input addr_strobe_n, addr_strobe_oe, transfer_dir, transfer_dir_oe, flow_pulse_n,
    input cycle_code, interlock_flag_n, user_mode, byte_lane_en_n, byte_lane_oe,
    input ad_cpu, ad_cpu_oe, bus_grant_ack_n, strobe_or_float_cpu, strobe_or_float_cpu_oe,
    input xlate_cpu, xlate_cpu_oe,
    output ad_sys, ad_sys_oe, hold_req_n, ready, int_req_n, nmi_req_n, reset_abort_n,
    output float_cmd_n, xlate_sys, xlate_sys_oe
  );
endinterface
`default_nettype wire

// ### rtl/csbpi_cpu.sv
// Processor end of the system bus: cycle sequencer, hold, reset/abort, straps
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Address strobe low starts each cycle
// - Direction low read, high write
// - One low flow pulse per instruction start
// - Four-bit cycle code, bit 0 LSB
// - Interlock flag low during interlocked instruction
// - Maskable and nonmaskable interrupt inputs
// - 24-bit address muxed with low data
// - Ready high ends the cycle
// - Ready low stretches the cycle
// - Hold request low releases the bus
// - Hold acknowledge low after bus released
// - Four active-low byte-lane enables
// - Reset/abort low one clock means abort
// - Low three clocks or longer resets; low exactly two clocks gives neither
// - Strobe/float pin role set by strap
// - Coprocessor transfers strobe on translation pin
// - Coprocessor signals completion on translation pin
// - Translation strap latched at reset release
// - Privilege output high user, low supervisor
// - Two-phase external clock source; here a single sys_clk_i clocks all the logic
// - Hold request timed before final state
// - Direction resumes after float withdrawn, same level
module csbpi_cpu
  import csbpi_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Pins
  csbpi_if.cpu pins,
  // Core request side
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_copro_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [LANE_W-1:0] req_lanes_i,
  input wire logic [CODE_W-1:0] req_code_i,
  input wire logic insn_start_i,
  input wire logic interlock_i,
  input wire logic user_mode_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic abort_o,
  output logic core_reset_o,
  output logic xlate_strap_o,
  output logic copro_done_o,
  output logic int_pend_o,
  output logic nmi_pend_o
);
  csbpi_state_t state;
  csbpi_state_t next_state;
  logic [2:0] rdy_s, hold_s, rst_s, flt_s, xl_s, int_s, nmi_s;
  logic rdy_q, hold_q, flt_q, xl_q, int_q, nmi_q;
  logic [3:0] low_cnt;
  logic in_reset;
  logic cyc_write, cyc_copro;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata;
  logic [LANE_W-1:0] cyc_lanes;
  logic [CODE_W-1:0] cyc_code;
  logic nmi_prev, xl_prev;

  // --------------------------------------------------------------
  // Pin synchronisers: change accepted when stages 2 and 3 agree
  // --------------------------------------------------------------
  wire logic [6:0] raw = {pins.ready, ~pins.hold_req_n, pins.reset_abort_n,
                          pins.float_cmd_n, pins.xlate_sys, pins.int_req_n, pins.nmi_req_n};
  always_ff @(posedge sys_clk_i)
  begin
    rdy_s <= {rdy_s[1:0], raw[6]};
    hold_s <= {hold_s[1:0], raw[5]};
    rst_s <= {rst_s[1:0], raw[4]};
    flt_s <= {flt_s[1:0], raw[3]};
    xl_s <= {xl_s[1:0], raw[2]};
    int_s <= {int_s[1:0], raw[1]};
    nmi_s <= {nmi_s[1:0], raw[0]};
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rdy_q <= 1'b0;
      hold_q <= 1'b0;
      flt_q <= 1'b1;
      xl_q <= 1'b1;
      int_q <= 1'b1;
      nmi_q <= 1'b1;
    end
    else
    begin
      if (rdy_s[1] == rdy_s[2]) rdy_q <= rdy_s[2];
      if (hold_s[1] == hold_s[2]) hold_q <= hold_s[2];
      if (flt_s[1] == flt_s[2]) flt_q <= flt_s[2];
      if (xl_s[1] == xl_s[2]) xl_q <= xl_s[2];
      if (int_s[1] == int_s[2]) int_q <= int_s[2];
      if (nmi_s[1] == nmi_s[2]) nmi_q <= nmi_s[2];
    end
  end

  // --------------------------------------------------------------
  // Reset/abort discrimination by low-time count
  // --------------------------------------------------------------
  // Timed on stage 3 alone: the agree filter would swallow a one-clock abort
  wire logic rst_low = !rst_s[2];
  wire logic rst_release = rst_s[2] && low_cnt != 4'h0;
  wire logic long_low = low_cnt > ABORT_CNT;
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      low_cnt <= 4'h0;
      in_reset <= 1'b0;
      abort_o <= 1'b0;
      core_reset_o <= 1'b0;
      xlate_strap_o <= 1'b0;
    end
    else
    begin
      if (rst_low && !long_low) low_cnt <= low_cnt + 4'h1;
      else if (!rst_low) low_cnt <= 4'h0;
      in_reset <= rst_low && long_low;
      abort_o <= rst_release && low_cnt == ABORT_CNT;
      core_reset_o <= rst_low && long_low;
      if (rst_release && in_reset) xlate_strap_o <= xl_q;
    end
  end

  // --------------------------------------------------------------
  // Bus cycle sequencer
  // --------------------------------------------------------------
  wire logic stop = core_reset_o || abort_o;
  always_comb
  begin
    next_state = state;
    case (state)
      CSB_IDLE: if (hold_q) next_state = CSB_HELD;
                else if (req_i) next_state = CSB_ADDR;
      CSB_ADDR: next_state = CSB_DATA;
      CSB_DATA: next_state = rdy_q ? CSB_IDLE : CSB_WAIT;
      CSB_WAIT: if (rdy_q) next_state = CSB_IDLE;
      CSB_HELD: if (!hold_q) next_state = CSB_IDLE;
      default: next_state = CSB_IDLE;
    endcase
    if (stop) next_state = CSB_IDLE;
  end
  wire logic take = state == CSB_IDLE && next_state == CSB_ADDR;
  wire logic finish = (state == CSB_DATA || state == CSB_WAIT) && rdy_q && !stop;
  wire logic active = state == CSB_ADDR || state == CSB_DATA || state == CSB_WAIT;
  wire logic drive = state != CSB_HELD;
  wire logic floated = !xlate_strap_o && !flt_q;
  wire logic strobe_ph = (state == CSB_DATA || state == CSB_WAIT);
  // Code and lane qualifiers fall back to idle values when held, so no stale cycle shows
  wire logic cyc_next = next_state == CSB_ADDR || next_state == CSB_DATA
                        || next_state == CSB_WAIT;

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i) state <= CSB_IDLE;
    else state <= next_state;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      cyc_write <= 1'b0;
      cyc_copro <= 1'b0;
      cyc_addr <= '0;
      cyc_wdata <= '0;
      cyc_lanes <= LANES_NONE;
      cyc_code <= CODE_IDLE;
    end
    else if (take)
    begin
      cyc_write <= req_write_i;
      cyc_copro <= req_copro_i;
      cyc_addr <= req_addr_i;
      cyc_wdata <= req_wdata_i;
      cyc_lanes <= ~req_lanes_i;
      cyc_code <= req_code_i;
    end
  end

  // --------------------------------------------------------------
  // Pin drivers, all registered
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      pins.addr_strobe_n <= 1'b1;
      pins.addr_strobe_oe <= 1'b1;
      pins.transfer_dir <= 1'b0;
      pins.transfer_dir_oe <= 1'b1;
      pins.cycle_code <= CODE_IDLE;
      pins.byte_lane_en_n <= LANES_NONE;
      pins.byte_lane_oe <= 1'b1;
      pins.ad_cpu <= '0;
      pins.ad_cpu_oe <= 1'b0;
      pins.bus_grant_ack_n <= 1'b1;
      pins.flow_pulse_n <= 1'b1;
      pins.interlock_flag_n <= 1'b1;
      pins.user_mode <= 1'b0;
      pins.strobe_or_float_cpu <= 1'b1;
      pins.strobe_or_float_cpu_oe <= 1'b0;
      pins.xlate_cpu <= 1'b1;
      pins.xlate_cpu_oe <= 1'b0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
    end
    else
    begin
      pins.addr_strobe_n <= !(next_state == CSB_ADDR);
      pins.addr_strobe_oe <= next_state != CSB_HELD;
      pins.transfer_dir <= take ? req_write_i : cyc_write;
      // Re-driven as soon as float drops; the translator drives the same level
      pins.transfer_dir_oe <= next_state != CSB_HELD && !floated;
      pins.cycle_code <= take ? req_code_i : (cyc_next ? cyc_code : CODE_IDLE);
      pins.byte_lane_en_n <= take ? ~req_lanes_i
                            : (cyc_next ? cyc_lanes : LANES_NONE);
      pins.byte_lane_oe <= next_state != CSB_HELD;
      pins.ad_cpu <= take ? {{UPPER_W{1'b0}}, req_addr_i} : cyc_wdata;
      pins.ad_cpu_oe <= next_state == CSB_ADDR && !floated
                        || (active && next_state != CSB_IDLE && cyc_write && state != CSB_IDLE);
      pins.bus_grant_ack_n <= !(state == CSB_HELD && next_state == CSB_HELD);
      pins.flow_pulse_n <= !insn_start_i;
      pins.interlock_flag_n <= !interlock_i;
      pins.user_mode <= user_mode_i;
      pins.strobe_or_float_cpu <= !(strobe_ph && !cyc_copro);
      pins.strobe_or_float_cpu_oe <= xlate_strap_o && drive;
      pins.xlate_cpu <= !(strobe_ph && cyc_copro);
      pins.xlate_cpu_oe <= cyc_copro && active && !in_reset;
      req_ready_o <= next_state == CSB_IDLE && !hold_q && !stop;
      done_o <= finish;
      if (finish && !cyc_write) rdata_o <= pins.ad_sys;
    end
  end

  // --------------------------------------------------------------
  // Interrupt and coprocessor completion flags to the core
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      nmi_prev <= 1'b1;
      xl_prev <= 1'b1;
      int_pend_o <= 1'b0;
      nmi_pend_o <= 1'b0;
      copro_done_o <= 1'b0;
    end
    else
    begin
      nmi_prev <= nmi_q;
      xl_prev <= xl_q;
      int_pend_o <= !int_q;
      nmi_pend_o <= nmi_prev && !nmi_q;
      copro_done_o <= xl_prev && !xl_q && !active && !in_reset && low_cnt == 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/csbpi_sys.sv
// System end of the bus: memory responder, hold master, reset and strap driver
`timescale 1ns/100ps
`default_nettype none
module csbpi_sys
  import csbpi_pkg::*;
#(
  parameter int WAIT_W = 4
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Pins
  csbpi_if.sys pins,
  // User controls
  input wire logic [WAIT_W-1:0] wait_cycles_i,
  input wire logic [DATA_W-1:0] read_data_i,
  input wire logic hold_want_i,
  input wire logic reset_abort_n_i,
  input wire logic xlate_strap_i,
  input wire logic float_n_i,
  input wire logic int_n_i,
  input wire logic nmi_n_i,
  input wire logic copro_ack_i,
  // Observed cycle
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic granted_o
);
  logic [WAIT_W-1:0] wcnt;
  logic in_cyc;

  // --------------------------------------------------------------
  // Address latch and ready generation
  // --------------------------------------------------------------
  wire logic cyc_start = !pins.addr_strobe_n && pins.addr_strobe_oe;
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      wcnt <= '0;
      in_cyc <= 1'b0;
      addr_o <= '0;
      wdata_o <= '0;
      wr_o <= 1'b0;
      granted_o <= 1'b0;
      pins.ready <= 1'b0;
      pins.ad_sys <= '0;
      pins.ad_sys_oe <= 1'b0;
      pins.hold_req_n <= 1'b1;
      pins.reset_abort_n <= 1'b1;
      pins.float_cmd_n <= 1'b1;
      pins.xlate_sys <= 1'b1;
      pins.xlate_sys_oe <= 1'b0;
      pins.int_req_n <= 1'b1;
      pins.nmi_req_n <= 1'b1;
    end
    else
    begin
      if (cyc_start)
      begin
        in_cyc <= 1'b1;
        wcnt <= wait_cycles_i;
        addr_o <= pins.ad_cpu[ADDR_W-1:0];
        wr_o <= pins.transfer_dir;
        pins.ready <= wait_cycles_i == '0;
      end
      else if (in_cyc)
      begin
        if (wcnt != '0) wcnt <= wcnt - WAIT_W'(1);
        pins.ready <= wcnt <= WAIT_W'(1);
        if (pins.ready) in_cyc <= 1'b0;
        if (pins.transfer_dir && pins.ad_cpu_oe) wdata_o <= pins.ad_cpu;
      end
      else pins.ready <= 1'b0;
      pins.ad_sys <= read_data_i;
      pins.ad_sys_oe <= in_cyc && !pins.transfer_dir && !pins.ad_cpu_oe;
      pins.hold_req_n <= !hold_want_i;
      granted_o <= !pins.bus_grant_ack_n;
      pins.reset_abort_n <= reset_abort_n_i;
      pins.float_cmd_n <= float_n_i;
      // Strap is held during reset, then the pin pulses low on completions
      pins.xlate_sys_oe <= !reset_abort_n_i || copro_ack_i;
      pins.xlate_sys <= reset_abort_n_i ? !copro_ack_i : xlate_strap_i;
      pins.int_req_n <= int_n_i;
      pins.nmi_req_n <= nmi_n_i;
    end
  end
endmodule
`default_nettype wire

// ### tb/csbpi_properties.sv
// Pin-level checks on the link between the processor end and the system end
`timescale 1ns/100ps
`default_nettype none
module csbpi_properties
  import csbpi_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Bus pins
  input wire logic addr_strobe_n,
  input wire logic addr_strobe_oe,
  input wire logic transfer_dir,
  input wire logic transfer_dir_oe,
  input wire logic flow_pulse_n,
  input wire logic [CODE_W-1:0] cycle_code,
  input wire logic [LANE_W-1:0] byte_lane_en_n,
  input wire logic byte_lane_oe,
  input wire logic ad_cpu_oe,
  input wire logic bus_grant_ack_n,
  input wire logic hold_req_n,
  input wire logic ready
);
  logic lanes_on;
  assign lanes_on = (byte_lane_en_n != LANES_NONE);
  default clocking dcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  strobe_one_a: assert property (!addr_strobe_n |=> addr_strobe_n)
    else $error("address strobe low for more than one cycle");
  strobe_drive_a: assert property (!addr_strobe_n |-> ad_cpu_oe && addr_strobe_oe)
    else $error("address not driven with strobe");
  flow_one_a: assert property (!flow_pulse_n |=> flow_pulse_n)
    else $error("flow pulse wider than one cycle");
  cycle_stable_a: assert property (lanes_on && $past(lanes_on) && addr_strobe_n
    |-> $stable(transfer_dir) && $stable(cycle_code) && $stable(byte_lane_en_n))
    else $error("cycle qualifiers moved mid cycle");
  wait_stretch_a: assert property (lanes_on && !ready && !$past(ready) && !$past(ready, 2)
    && !$past(ready, 3) && !$past(ready, 4) |=> lanes_on)
    else $error("cycle ended while ready low");
  ready_end_a: assert property ($rose(ready) && lanes_on |-> ##[1:10] !lanes_on)
    else $error("cycle not ended after ready");
  code_idle_a: assert property ($rose(&byte_lane_en_n) |-> cycle_code == CODE_IDLE)
    else $error("cycle code not idle after cycle");
  grant_float_a: assert property (!bus_grant_ack_n |-> !ad_cpu_oe && !addr_strobe_oe
    && !byte_lane_oe && !transfer_dir_oe)
    else $error("bus driven while granted away");
  grant_cause_a: assert property ($fell(bus_grant_ack_n) |-> !hold_req_n)
    else $error("grant without hold request");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench joining the processor end to the system end
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import csbpi_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_i = 1'b0, req_write_i = 1'b0, req_copro_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = '0, addr_o;
  logic [DATA_W-1:0] req_wdata_i = '0, read_data_i = '0, rdata_o, wdata_o;
  logic [LANE_W-1:0] req_lanes_i = 4'hf;
  logic [CODE_W-1:0] req_code_i = 4'h9;
  logic insn_start_i = 1'b0, interlock_i = 1'b0, user_mode_i = 1'b0;
  logic [3:0] wait_cycles_i = 4'h0;
  logic hold_want_i = 1'b0, reset_abort_n_i = 1'b1, xlate_strap_i = 1'b0, float_n_i = 1'b1;
  logic int_n_i = 1'b1, nmi_n_i = 1'b1, copro_ack_i = 1'b0;
  logic req_ready_o, done_o, abort_o, core_reset_o, xlate_strap_o, copro_done_o;
  logic int_pend_o, nmi_pend_o, wr_o, granted_o, xseen, dseen;
  logic [3:0] lseen, cseen;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  always #2 sys_clk_i = ~sys_clk_i; // One clock stands in for both phases
  csbpi_if pins();
  csbpi_cpu csbpi_cpu_i (.sys_clk_i, .reset_n_i, .pins(pins), .req_i, .req_write_i,
    .req_copro_i, .req_addr_i, .req_wdata_i, .req_lanes_i, .req_code_i, .insn_start_i,
    .interlock_i, .user_mode_i, .req_ready_o, .done_o, .rdata_o, .abort_o, .core_reset_o,
    .xlate_strap_o, .copro_done_o, .int_pend_o, .nmi_pend_o);
  csbpi_sys csbpi_sys_i (.sys_clk_i, .reset_n_i, .pins(pins), .wait_cycles_i, .read_data_i,
    .hold_want_i, .reset_abort_n_i, .xlate_strap_i, .float_n_i, .int_n_i, .nmi_n_i,
    .copro_ack_i, .addr_o, .wdata_o, .wr_o, .granted_o);
  csbpi_properties csbpi_properties_i (.sys_clk_i, .reset_n_i,
    .addr_strobe_n(pins.addr_strobe_n), .addr_strobe_oe(pins.addr_strobe_oe),
    .transfer_dir(pins.transfer_dir), .transfer_dir_oe(pins.transfer_dir_oe),
    .flow_pulse_n(pins.flow_pulse_n), .cycle_code(pins.cycle_code),
    .byte_lane_en_n(pins.byte_lane_en_n), .byte_lane_oe(pins.byte_lane_oe),
    .ad_cpu_oe(pins.ad_cpu_oe), .bus_grant_ack_n(pins.bus_grant_ack_n),
    .hold_req_n(pins.hold_req_n), .ready(pins.ready));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic pr(input int k);
    case (k)
      1: pr = abort_o;
      2: pr = core_reset_o;
      4: pr = copro_done_o;
      5: pr = int_pend_o;
      6: pr = nmi_pend_o;
      7: pr = pins.bus_grant_ack_n;
      8: pr = pins.transfer_dir_oe;
      9: pr = pins.flow_pulse_n;
      10: pr = pins.interlock_flag_n;
      11: pr = pins.user_mode;
      default: pr = req_ready_o;
    endcase
  endfunction
  // Bounded wait: a hang shows as one mismatch, not a stuck run
  task automatic wait_is(input int k, input logic v, input int lim);
    int n;
    // Step off the launching edge so a one-cycle output is seen
    #1;
    n = 0;
    while (pr(k) !== v && n < lim)
    begin
      tick;
      n++;
    end
    chk(32'(pr(k)), 32'(v));
  endtask
  task automatic do_cycle(input logic w, input logic cp, input logic [23:0] a,
    input logic [31:0] d, input logic [3:0] ln, input logic [3:0] wt, output int n);
    wait_is(12, 1'b1, 20);
    @(posedge sys_clk_i);
    req_i <= 1'b1;
    req_write_i <= w;
    req_copro_i <= cp;
    req_addr_i <= a;
    req_wdata_i <= d;
    read_data_i <= d;
    req_lanes_i <= ln;
    wait_cycles_i <= wt;
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    n = 0;
    xseen = 1'b0;
    while (done_o !== 1'b1 && n < 60)
    begin
      tick;
      n++;
      if (pins.byte_lane_en_n != LANES_NONE)
      begin
        lseen = pins.byte_lane_en_n;
        dseen = pins.transfer_dir;
        cseen = pins.cycle_code;
      end
      if (pins.xlate_cpu_oe === 1'b1)
        xseen = 1'b1;
    end
    chk(32'(done_o), 32'h1);
    chk(32'({dseen, lseen, cseen}), 32'({w, ~ln, req_code_i}));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write;
    int n;
    do_cycle(1'b1, 1'b0, 24'ha5c33c, 32'hdeadbeef, 4'h5, 4'h0, n);
    chk({wr_o, addr_o, 7'h0}, {1'b1, 24'ha5c33c, 7'h0});
    chk(wdata_o, 32'hdeadbeef);
  endtask
  task automatic t_read;
    int n0;
    int n6;
    do_cycle(1'b0, 1'b0, 24'h000001, 32'h12345678, 4'hf, 4'h0, n0);
    chk(rdata_o, 32'h12345678);
    do_cycle(1'b0, 1'b0, 24'hfffffe, 32'h8001c3a5, 4'h8, 4'h6, n6);
    chk(rdata_o, 32'h8001c3a5);
    chk(32'(n6 >= n0 + 6), 32'h1);
  endtask
  task automatic t_copro;
    int n;
    do_cycle(1'b1, 1'b1, 24'h000040, 32'h0f0f0f0f, 4'h3, 4'h0, n);
    chk(32'(xseen), 32'h1);
    @(posedge sys_clk_i);
    copro_ack_i <= 1'b1;
    // Two clocks: the pin filter drops one-clock pulses
    repeat (2) @(posedge sys_clk_i);
    copro_ack_i <= 1'b0;
    wait_is(4, 1'b1, 12);
  endtask
  task automatic t_hold;
    @(posedge sys_clk_i);
    hold_want_i <= 1'b1;
    wait_is(7, 1'b0, 16);
    chk(32'({pins.ad_cpu_oe, req_ready_o}), 32'h0);
    tick;
    chk(32'(granted_o), 32'h1);
    @(posedge sys_clk_i);
    hold_want_i <= 1'b0;
    wait_is(7, 1'b1, 16);
  endtask
  task automatic rst_pulse(input int n, input logic s);
    @(posedge sys_clk_i);
    reset_abort_n_i <= 1'b0;
    xlate_strap_i <= s;
    repeat (n) @(posedge sys_clk_i);
    reset_abort_n_i <= 1'b1;
  endtask
  task automatic t_abort;
    rst_pulse(1, 1'b0);
    wait_is(1, 1'b1, 12);
    chk(32'(core_reset_o), 32'h0);
    rst_pulse(4, 1'b1);
    wait_is(2, 1'b1, 10);
    wait_is(2, 1'b0, 12);
    chk(32'(xlate_strap_o), 32'h1);
    rst_pulse(4, 1'b0);
    wait_is(2, 1'b1, 10);
    wait_is(2, 1'b0, 12);
    chk(32'(xlate_strap_o), 32'h0);
  endtask
  task automatic t_float;
    wait_is(12, 1'b1, 20);
    @(posedge sys_clk_i);
    float_n_i <= 1'b0;
    tick;
    wait_is(8, 1'b0, 12);
    @(posedge sys_clk_i);
    float_n_i <= 1'b1;
    tick;
    wait_is(8, 1'b1, 12);
  endtask
  task automatic t_side;
    @(posedge sys_clk_i);
    insn_start_i <= 1'b1;
    @(posedge sys_clk_i);
    insn_start_i <= 1'b0;
    wait_is(9, 1'b0, 8);
    @(posedge sys_clk_i);
    interlock_i <= 1'b1;
    user_mode_i <= 1'b1;
    int_n_i <= 1'b0;
    nmi_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nmi_n_i <= 1'b1;
    wait_is(6, 1'b1, 12);
    wait_is(5, 1'b1, 12);
    wait_is(10, 1'b0, 8);
    wait_is(11, 1'b1, 8);
    @(posedge sys_clk_i);
    interlock_i <= 1'b0;
    user_mode_i <= 1'b0;
    int_n_i <= 1'b1;
    tick;
    wait_is(10, 1'b1, 8);
    wait_is(11, 1'b0, 8);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      close_out;
    end
  end
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_side;
    t_write;
    t_read;
    t_copro;
    t_hold;
    t_abort;
    t_float;
    close_out;
  end
endmodule
`default_nettype wire
